// ==== asrp_pkg.sv ====
// package for the serial result port: frame timing, widths and states.
// assumes a single system clock; the serial clock and select are pins.
package asrp_pkg;
    localparam int unsigned RES_W      = 10;
    localparam int unsigned CNT_W      = 5;
    // falling edge counts within a frame
    localparam logic [4:0]  FALL_NULL  = 5'h02;   // null bit driven here
    localparam logic [4:0]  FALL_MSB   = 5'h03;   // top result bit
    localparam logic [4:0]  FALL_LSB   = 5'h0C;   // bit 0, end of forward pass
    localparam logic [4:0]  FALL_LAST  = 5'h15;   // bit 9 of the reverse pass
    localparam logic [9:0]  CODE_ZERO  = 10'h000;
    localparam logic [9:0]  CODE_FULL  = 10'h3FF;
    localparam int unsigned FIFO_DEPTH = 16;
    typedef enum logic [1:0] {
        ASRP_ARMING  = 2'b00,  // waiting for select to be seen high
        ASRP_IDLE    = 2'b01,  // standby, select high
        ASRP_FRAME   = 2'b11   // select low, frame running
    } asrp_state_t;
endpackage

// ==== asrp_fifo.sv ====
// parameterised synchronous fifo holding conversion results.
// assumes one clock; writer and reader both honour valid and ready.
`timescale 1ns/100ps
`default_nettype none
module asrp_fifo #(
    parameter int unsigned WIDTH = 10,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } asrp_fifo_st_t;
    asrp_fifo_st_t    s_reg, s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push, pop;

    // honest flags from the fill count
    assign in_ready_o  = (s_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_reg.cnt != '0);
    assign out_data_o  = mem[s_reg.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        s_next = s_reg;
        if (push) s_next.wr = s_reg.wr + 1'b1;
        if (pop) s_next.rd = s_reg.rd + 1'b1;
        if (push && !pop) s_next.cnt = s_reg.cnt + 1'b1;
        else if (pop && !push) s_next.cnt = s_reg.cnt - 1'b1;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) s_reg <= '0;
        else s_reg <= s_next;
    end

    // storage has no reset, only written entries are ever read
    always_ff @(posedge clk_sys_i) begin
        if (push) mem[s_reg.wr] <= in_data_i;
    end
endmodule
`default_nettype wire

// ==== asrp_port.sv ====
// serial result port: shifts a 10-bit code out under an external clock.
// assumes serial clock and select are asynchronous pins, sampled by clk_sys_i;
// the serial clock must be well below a quarter of the system clock.
`timescale 1ns/100ps
`default_nettype none
module asrp_port (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       sclk_i,
    input  wire logic       select_and_sleep_n_i,
    output logic            sdo_o,
    output logic            sdo_oe_o,
    output logic            standby_o,
    output logic            sampling_o,
    input  wire logic [9:0] sample_code_i,
    input  wire logic       sample_under_i,
    input  wire logic       sample_over_i,
    input  wire logic       sample_valid_i,
    output logic            sample_ready_o
);
    typedef struct packed {
        asrp_pkg::asrp_state_t st;
        logic [1:0]            sclk_sy;
        logic [1:0]            cs_sy;
        logic                  sclk_d;
        logic [4:0]            falls;
        logic                  rose;
        logic                  samp;
        logic [9:0]            code;
        logic                  have;
        logic                  sdo;
        logic                  oe;
    } asrp_port_st_t;

    asrp_port_st_t s_reg, s_next;
    logic          sclk_rise, sclk_fall, cs_n;
    logic [9:0]    fifo_code;
    logic          fifo_valid, fifo_take;
    logic [9:0]    sat_code;

    // ------------------------------------------------------------
    // result buffer
    // ------------------------------------------------------------
    // the converter core may run ahead; its stall reaches it via ready
    asrp_fifo #(
        .WIDTH (asrp_pkg::RES_W),
        .DEPTH (asrp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .in_data_i   (sat_code),
        .in_valid_i  (sample_valid_i),
        .in_ready_o  (sample_ready_o),
        .out_data_o  (fifo_code),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_take)
    );

    // saturate the code at the rails
    always_comb begin
        if (sample_under_i) sat_code = asrp_pkg::CODE_ZERO;
        else if (sample_over_i) sat_code = asrp_pkg::CODE_FULL;
        else sat_code = sample_code_i;
    end

    // ------------------------------------------------------------
    // edge detection on synchronised pins
    // ------------------------------------------------------------
    assign sclk_rise = s_reg.sclk_sy[1] && !s_reg.sclk_d;
    assign sclk_fall = !s_reg.sclk_sy[1] && s_reg.sclk_d;
    assign cs_n      = s_reg.cs_sy[1];
    // the result is latched when the sample window closes
    assign fifo_take = (s_reg.st == asrp_pkg::ASRP_FRAME) && sclk_fall
                       && (s_reg.falls == asrp_pkg::FALL_NULL - 5'h01)
                       && s_reg.rose && fifo_valid;

    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] nf;
        logic [3:0] idx;
        nf  = s_reg.falls + 5'h01;
        idx = 4'h0;
        s_next         = s_reg;
        s_next.sclk_sy = {s_reg.sclk_sy[0], sclk_i};
        s_next.cs_sy   = {s_reg.cs_sy[0], select_and_sleep_n_i};
        s_next.sclk_d  = s_reg.sclk_sy[1];
        case (s_reg.st)
            asrp_pkg::ASRP_ARMING: begin
                // a select already low at power-up opens nothing
                if (cs_n) s_next.st = asrp_pkg::ASRP_IDLE;
            end
            asrp_pkg::ASRP_IDLE: begin
                s_next.falls = '0;
                s_next.rose  = 1'b0;
                s_next.samp  = 1'b0;
                s_next.oe    = 1'b0;
                s_next.sdo   = 1'b0;
                if (!cs_n) s_next.st = asrp_pkg::ASRP_FRAME;
            end
            asrp_pkg::ASRP_FRAME: begin
                if (cs_n) begin
                    // abort at once, the next low opens a fresh frame
                    s_next.st   = asrp_pkg::ASRP_IDLE;
                    s_next.oe   = 1'b0;
                    s_next.samp = 1'b0;
                    s_next.falls = '0;
                end else begin
                    if (sclk_rise && !s_reg.rose) begin
                        s_next.rose = 1'b1;
                        s_next.samp = 1'b1;
                    end
                    // falls before the first rise (mode 1,1 idle high) are ignored
                    if (sclk_fall && s_reg.rose) begin
                        if (s_reg.falls != 5'h1F) s_next.falls = nf;
                        if (nf == asrp_pkg::FALL_NULL) begin
                            s_next.samp = 1'b0;
                            s_next.oe   = 1'b1;
                            s_next.sdo  = 1'b0;
                            s_next.code = fifo_valid ? fifo_code : s_reg.code;
                            s_next.have = fifo_valid;
                        end else if (nf >= asrp_pkg::FALL_MSB
                                     && nf <= asrp_pkg::FALL_LSB) begin
                            idx = 4'(asrp_pkg::FALL_LSB - nf);
                            s_next.sdo = s_reg.code[idx];
                        end else if (nf > asrp_pkg::FALL_LSB
                                     && nf <= asrp_pkg::FALL_LAST) begin
                            idx = 4'(nf - asrp_pkg::FALL_LSB);
                            s_next.sdo = s_reg.code[idx];
                        end else if (nf > asrp_pkg::FALL_LAST) begin
                            s_next.sdo = 1'b0;
                        end
                    end
                end
            end
            default: s_next.st = asrp_pkg::ASRP_ARMING;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_reg    <= '0;
            s_reg.st <= asrp_pkg::ASRP_ARMING;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from flip-flops, except standby_o which is decoded from the state
    assign sdo_o      = s_reg.sdo;
    assign sdo_oe_o   = s_reg.oe;
    assign standby_o  = (s_reg.st != asrp_pkg::ASRP_FRAME);
    assign sampling_o = s_reg.samp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_data_on_fall: assert property (
        $changed(sdo_o) |-> $past(sclk_fall) || $past(cs_n))
        else $error("data changed away from a falling edge");
    a_hiz_early: assert property (
        (s_reg.st == asrp_pkg::ASRP_FRAME && s_reg.falls < asrp_pkg::FALL_NULL)
        |-> !sdo_oe_o)
        else $error("output driven in the first two clocks");
    a_null_low: assert property (
        (sclk_fall && s_reg.rose && !cs_n && s_reg.st == asrp_pkg::ASRP_FRAME
         && s_reg.falls == 5'h01) |=> (sdo_oe_o && !sdo_o && !sampling_o))
        else $error("null bit not low or window still open");
    a_msb_third: assert property (
        (sclk_fall && s_reg.rose && !cs_n && s_reg.st == asrp_pkg::ASRP_FRAME
         && s_reg.falls == 5'h02) |=> sdo_o == s_reg.code[9])
        else $error("top bit not on third falling edge");
    a_lsb_pass: assert property (
        (sclk_fall && s_reg.rose && !cs_n && s_reg.st == asrp_pkg::ASRP_FRAME
         && s_reg.falls == 5'h0C) |=> sdo_o == s_reg.code[1])
        else $error("reverse pass did not continue with bit 1");
    a_zero_tail: assert property (
        (s_reg.st == asrp_pkg::ASRP_FRAME && s_reg.falls > asrp_pkg::FALL_LAST)
        |-> !sdo_o)
        else $error("trailing bits not zero");
    a_abort_frame: assert property (
        (s_reg.st == asrp_pkg::ASRP_FRAME && cs_n) |=> (!sdo_oe_o && standby_o)
        ##1 (s_reg.falls == '0))
        else $error("select high did not end the frame");
    a_arm_first: assert property (
        (s_reg.st == asrp_pkg::ASRP_ARMING) |=> (s_reg.st != asrp_pkg::ASRP_FRAME))
        else $error("frame opened without select seen high");
    a_sample_start: assert property (
        (s_reg.st == asrp_pkg::ASRP_FRAME && !cs_n && sclk_rise && !s_reg.rose)
        |=> sampling_o)
        else $error("sampling did not start on first rise");
    a_saturate: assert property (
        sample_over_i && !sample_under_i |-> sat_code == asrp_pkg::CODE_FULL)
        else $error("over-range code not saturated");

    c_full_frame: cover property (
        s_reg.st == asrp_pkg::ASRP_FRAME && s_reg.falls == asrp_pkg::FALL_LAST);
    c_abort: cover property (
        s_reg.st == asrp_pkg::ASRP_FRAME && cs_n && s_reg.falls == 5'h0A);
    c_fifo_full: cover property (!sample_ready_o);
endmodule
`default_nettype wire

// ==== asrp_master_model.sv ====
// master model for the serial result port: drives select and clock, samples data on rises.
// assumes the bench feeds it the resolved data line and the pin's output enable.
`timescale 1ns/100ps
`default_nettype none
module asrp_master_model (
    input  wire logic data_line_i,
    input  wire logic data_oe_i,
    output logic      sclk_o,
    output logic      select_n_o
);
    // low phase longer than high: the port answers two to three system clocks after a fall
    localparam int LOW_NS  = 250;
    localparam int HIGH_NS = 150;
    logic [31:0] data_seen;
    logic [31:0] oe_seen;
    event        done;
    // select starts low to model power-up with the pin already asserted
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b0;
    end
    // clock pulses only; capture always on the rising edge
    task automatic clocks(input int n, input bit idle_high);
        data_seen = '0;
        oe_seen = '0;
        for (int i = 0; i < n; i++) begin
            sclk_o = ~idle_high;
            #(idle_high ? LOW_NS : 0);
            sclk_o = 1'b1;
            data_seen[i] = data_line_i;
            oe_seen[i] = data_oe_i;
            #HIGH_NS;
            sclk_o = idle_high;
            #(idle_high ? 0 : LOW_NS);
        end
    endtask
    // whole frame: high first, then low, then clocks, then released
    task automatic frame(input int n, input bit idle_high);
        sclk_o = idle_high;
        select_n_o = 1'b1;
        #500;
        select_n_o = 1'b0;
        #300;
        clocks(n, idle_high);
        select_n_o = 1'b1;
        #500;
        -> done;
    endtask
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// testbench for the serial result port: fifo fed with codes, frames read by the master model.
// assumes the port and fifo design files and the package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       sclk;
    logic       sel_n;
    logic       sdo;
    logic       sdo_oe;
    logic       standby;
    logic       sampling;
    logic [9:0] code = 10'h000;
    logic       under = 1'b0;
    logic       over = 1'b0;
    logic       valid = 1'b0;
    logic       ready;
    logic       last_drv = 1'b0;
    wire        data_line;
    int         num_errors = 0;
    int         total_checks = 0;
    int         seed = 31799;
    int         frame_len = 16;
    logic [9:0] exp_q[$];
    logic [9:0] last_exp = 10'h000;
    int         lens[5] = '{16, 16, 31, 11, 24};

    always #25 clk_sys = ~clk_sys;

    // sampling window length in system clocks, latched as the window closes
    logic [7:0] samp_cnt = 8'h00;
    logic [7:0] samp_len = 8'h00;
    always_ff @(posedge clk_sys) begin
        samp_cnt <= sampling ? samp_cnt + 8'h01 : 8'h00;
        if (!sampling && samp_cnt != 8'h00) samp_len <= samp_cnt;
    end

    asrp_port DUT (.clk_sys_i(clk_sys), .rst_i(rst), .sclk_i(sclk),
        .select_and_sleep_n_i(sel_n), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
        .standby_o(standby), .sampling_o(sampling), .sample_code_i(code),
        .sample_under_i(under), .sample_over_i(over), .sample_valid_i(valid),
        .sample_ready_o(ready));
    asrp_master_model master (.data_line_i(data_line), .data_oe_i(sdo_oe),
        .sclk_o(sclk), .select_n_o(sel_n));

    // released line shows the inverse of the last driven bit, never a lucky match
    always_ff @(posedge clk_sys) if (sdo_oe) last_drv <= sdo;
    assign data_line = sdo_oe ? sdo : ~last_drv;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // slot k holds what fall k drove: null, forward pass, reverse pass, zeros
    function automatic logic [31:0] frame_bits(input logic [9:0] c, input int n);
        logic [31:0] b;
        b = '0;
        for (int i = 3; i < n; i++) begin
            if (i <= 12) b[i] = c[12 - i];
            else if (i <= 21) b[i] = c[i - 12];
        end
        return b;
    endfunction

    // offers one word and notes its expected code once the fifo takes it
    task automatic put_word(input logic [9:0] c, input logic u, input logic o);
        code <= c;
        under <= u;
        over <= o;
        valid <= 1'b1;
        @(posedge clk_sys);
        for (int k = 0; k < 50 && ready !== 1'b1; k++) @(posedge clk_sys);
        last_exp = u ? asrp_pkg::CODE_ZERO : (o ? asrp_pkg::CODE_FULL : c);
        exp_q.push_back(last_exp);
    endtask

    task automatic run(input int n, input bit mode);
        @(posedge clk_sys);
        #7;
        frame_len = n;
        master.frame(n, mode);
    endtask

    // watcher: compares each finished frame with the oldest note
    initial begin : watch
        logic [9:0]  c;
        logic [31:0] m;
        logic [7:0]  hi;
        logic [7:0]  lo;
        forever begin
            @(master.done);
            c = exp_q.pop_front();
            m = (32'h1 << frame_len) - 32'h1;
            check(master.oe_seen & m, m & ~32'h3);
            check(master.data_seen & m & ~32'h3,
                  frame_bits(c, frame_len));
            // one 400 ns period plus the 150 ns high phase, 550 ns at 50 ns per system clock
            check({24'h0, samp_len}, 32'h0000000B);
            // a byte master drops the repeated bits and joins the two bytes
            if (frame_len == 16) begin
                for (int k = 0; k < 8; k++) begin
                    hi[7 - k] = master.data_seen[k];
                    lo[7 - k] = master.data_seen[8 + k];
                end
                lo = lo >> 3;
                check({22'h0, hi[4:0], lo[4:0]}, {22'h0, c});
            end
        end
    end

    initial begin : main
        int r;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #7;
        master.clocks(16, 1'b0);
        check(master.oe_seen, 32'h0);
        check({31'h0, standby}, 32'h1);
        // fill until refused; entries 1..3 carry under, over and both
        for (int i = 0; i < asrp_pkg::FIFO_DEPTH; i++) begin
            r = $random(seed);
            put_word(r[9:0], i == 1 || i == 3, i == 2 || i == 3);
        end
        code <= 10'h155;
        repeat (3) @(posedge clk_sys);
        check({31'h0, ready}, 32'h0);
        valid <= 1'b0;
        // drain in both clock modes, full, byte-sized and cut-short frames
        for (int i = 0; i < asrp_pkg::FIFO_DEPTH; i++) begin
            run(lens[i % 5], i % 2);
        end
        check({31'h0, ready}, 32'h1);
        exp_q.push_back(last_exp);
        run(31, 1'b0);
        // let the watcher finish the last frame before the verdict
        repeat (2) @(posedge clk_sys);
        check({31'h0, standby}, 32'h1);
        stop_test();
    end

    initial begin : watchdog
        #1000000;
        num_errors++;
        stop_test();
    end
endmodule
`default_nettype wire
